// ==== shared/iic_defines.svh ====
`ifndef IIC_DEFINES_SVH
`define IIC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define IIC_TX_EVT_SET   8'h90
`define IIC_TX_EVT_CLR   8'h94
`define IIC_TX_MASK_SET  8'h98
`define IIC_TX_MASK_CLR  8'h9C
`define IIC_RX_EVT_SET   8'hA0
`define IIC_RX_EVT_CLR   8'hA4

// ****************************************
// Field layout and reset values
// ****************************************
`define IIC_TX_CTX       8
`define IIC_RX_CTX       4
`define IIC_TOP_TX_BIT   6
`define IIC_TOP_RX_BIT   7
`define IIC_TOP_MIE_BIT  31
`define IIC_EVT_RESET    1'h0
`define IIC_MASK_RESET   1'h0

`endif

// ==== shared/iic_pkg.sv ====
package iic_pkg;

  typedef logic [31:0] iic_word_t;

  typedef enum logic [2:0] {
    IIC_SEL_NONE    = 3'h0,
    IIC_SEL_TX_EVTS = 3'h1,
    IIC_SEL_TX_EVTC = 3'h3,
    IIC_SEL_TX_MSK  = 3'h2,
    IIC_SEL_RX_EVTS = 3'h6,
    IIC_SEL_RX_EVTC = 3'h7
  } iic_sel_t;

endpackage : iic_pkg

// ==== rtl/iic_event_bank.sv ====
`timescale 1ns/100ps
`include "iic_defines.svh"

module iic_event_bank #(
  parameter int W = 8
) (
  input  wire logic         mclk,      // Controller clock
  input  wire logic         reset,     // Sync reset, high
  input  wire logic [W-1:0] ctx_irq,   // Context interrupt levels
  input  wire logic         set_we,    // Write at set address
  input  wire logic         clr_we,    // Write at clear address
  input  wire logic [W-1:0] wdata,     // Write data, low bits
  output logic      [W-1:0] events_r   // Sticky event bits
);

  logic [W-1:0] irq_prev_r;
  logic [W-1:0] rise;
  logic [W-1:0] set_bits;
  logic [W-1:0] clr_bits;

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_prev_r <= '0;
    end else begin
      irq_prev_r <= ctx_irq;
    end
  end

  assign rise     = ctx_irq & ~irq_prev_r;
  assign set_bits = rise | (set_we ? wdata : '0);
  assign clr_bits = clr_we ? wdata : '0;

  // Set wins so an edge in the clearing cycle survives
  always_ff @(posedge mclk) begin
    if (reset) begin
      events_r <= {W{`IIC_EVT_RESET}};
    end else begin
      events_r <= (events_r & ~clr_bits) | set_bits;
    end
  end

endmodule : iic_event_bank

// ==== rtl/iic_mask_bank.sv ====
`timescale 1ns/100ps
`include "iic_defines.svh"

module iic_mask_bank #(
  parameter int W = 8
) (
  input  wire logic         mclk,     // Controller clock
  input  wire logic         reset,    // Sync reset, high
  input  wire logic         set_we,   // Write at mask set address
  input  wire logic         clr_we,   // Write at mask clear address
  input  wire logic [W-1:0] wdata,    // Write data, low bits
  output logic      [W-1:0] mask_r    // Per-context enables
);

  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_r <= {W{`IIC_MASK_RESET}};
    end else if (set_we) begin
      mask_r <= mask_r | wdata;
    end else if (clr_we) begin
      mask_r <= mask_r & ~wdata;
    end
  end

endmodule : iic_mask_bank

// ==== rtl/iic_regs.sv ====
`timescale 1ns/100ps
`include "iic_defines.svh"

module iic_regs #(
  parameter int TXN = `IIC_TX_CTX,
  parameter int RXN = `IIC_RX_CTX
) (
  input  wire logic           mclk,                  // Controller clock
  input  wire logic           reset,                 // Sync reset, high
  input  wire logic [7:0]     reg_addr,              // Byte offset
  input  wire logic           reg_wr,                // Write strobe
  input  wire logic           reg_rd,                // Read strobe
  input  wire logic [31:0]    reg_wdata,             // Write data
  output iic_pkg::iic_word_t  reg_rdata_r,           // Read data
  output logic                reg_ack_r,             // Access done pulse
  input  wire logic [TXN-1:0] tx_ctx_irq,            // Tx context irqs
  input  wire logic [RXN-1:0] rx_ctx_irq,            // Rx context irqs
  input  wire logic [RXN-1:0] rx_mask,               // Rx enables, external
  input  wire logic [31:0]    top_irq_mask,          // Top-level mask
  output logic                tx_iso_summary_event,  // Top bit 6 level
  output logic                rx_iso_summary_event,  // Top bit 7 level
  output logic [31:0]         top_iso_events_r,      // Summary bits placed
  output logic                irq_out_r              // External interrupt
);

  // ****************************************
  // Decode
  // ****************************************
  iic_pkg::iic_sel_t sel;
  logic              tx_evt_set_we;
  logic              tx_evt_clr_we;
  logic              tx_msk_set_we;
  logic              tx_msk_clr_we;
  logic              rx_evt_set_we;
  logic              rx_evt_clr_we;

  always_comb begin
    case (reg_addr)
      `IIC_TX_EVT_SET:  sel = iic_pkg::IIC_SEL_TX_EVTS;
      `IIC_TX_EVT_CLR:  sel = iic_pkg::IIC_SEL_TX_EVTC;
      `IIC_TX_MASK_SET: sel = iic_pkg::IIC_SEL_TX_MSK;
      `IIC_TX_MASK_CLR: sel = iic_pkg::IIC_SEL_TX_MSK;
      `IIC_RX_EVT_SET:  sel = iic_pkg::IIC_SEL_RX_EVTS;
      `IIC_RX_EVT_CLR:  sel = iic_pkg::IIC_SEL_RX_EVTC;
      default:          sel = iic_pkg::IIC_SEL_NONE;
    endcase
  end

  assign tx_evt_set_we = reg_wr && (reg_addr == `IIC_TX_EVT_SET);
  assign tx_evt_clr_we = reg_wr && (reg_addr == `IIC_TX_EVT_CLR);
  assign tx_msk_set_we = reg_wr && (reg_addr == `IIC_TX_MASK_SET);
  assign tx_msk_clr_we = reg_wr && (reg_addr == `IIC_TX_MASK_CLR);
  assign rx_evt_set_we = reg_wr && (reg_addr == `IIC_RX_EVT_SET);
  assign rx_evt_clr_we = reg_wr && (reg_addr == `IIC_RX_EVT_CLR);

  // ****************************************
  // Event and mask storage
  // ****************************************
  logic [TXN-1:0] tx_events;
  logic [TXN-1:0] tx_mask;
  logic [RXN-1:0] rx_events;

  iic_event_bank #(.W(TXN)) u_tx_events (
    .mclk     (mclk),
    .reset    (reset),
    .ctx_irq  (tx_ctx_irq),
    .set_we   (tx_evt_set_we),
    .clr_we   (tx_evt_clr_we),
    .wdata    (reg_wdata[TXN-1:0]),
    .events_r (tx_events)
  );

  iic_event_bank #(.W(RXN)) u_rx_events (
    .mclk     (mclk),
    .reset    (reset),
    .ctx_irq  (rx_ctx_irq),
    .set_we   (rx_evt_set_we),
    .clr_we   (rx_evt_clr_we),
    .wdata    (reg_wdata[RXN-1:0]),
    .events_r (rx_events)
  );

  iic_mask_bank #(.W(TXN)) u_tx_mask (
    .mclk   (mclk),
    .reset  (reset),
    .set_we (tx_msk_set_we),
    .clr_we (tx_msk_clr_we),
    .wdata  (reg_wdata[TXN-1:0]),
    .mask_r (tx_mask)
  );

  // ****************************************
  // Read path
  // ****************************************
  iic_pkg::iic_word_t rdata_nxt;

  always_comb begin
    rdata_nxt = '0;
    case (sel)
      iic_pkg::IIC_SEL_TX_EVTS: rdata_nxt[TXN-1:0] = tx_events;
      iic_pkg::IIC_SEL_TX_EVTC: rdata_nxt[TXN-1:0] = tx_events & tx_mask;
      iic_pkg::IIC_SEL_TX_MSK:  rdata_nxt[TXN-1:0] = tx_mask;
      iic_pkg::IIC_SEL_RX_EVTS: rdata_nxt[RXN-1:0] = rx_events;
      iic_pkg::IIC_SEL_RX_EVTC: rdata_nxt[RXN-1:0] = rx_events & rx_mask;
      default:                  rdata_nxt = '0;
    endcase
  end

  // Read data hold until the next read; state is sampled before writes land
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata_r <= '0;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_ack_r <= 1'b0;
    end else begin
      reg_ack_r <= reg_rd | reg_wr;
    end
  end

  // ****************************************
  // Summary and external interrupt
  // ****************************************
  logic [31:0] top_nxt;

  always_comb begin
    top_nxt = '0;
    top_nxt[`IIC_TOP_TX_BIT] = |(tx_events & tx_mask);
    top_nxt[`IIC_TOP_RX_BIT] = |(rx_events & rx_mask);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      top_iso_events_r <= '0;
    end else begin
      top_iso_events_r <= top_nxt;
    end
  end

  assign tx_iso_summary_event = top_iso_events_r[`IIC_TOP_TX_BIT];
  assign rx_iso_summary_event = top_iso_events_r[`IIC_TOP_RX_BIT];

  // Gated one cycle after the summary so it follows the visible bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_out_r <= 1'b0;
    end else begin
      irq_out_r <= top_irq_mask[`IIC_TOP_MIE_BIT]
                   && |(top_iso_events_r & top_irq_mask);
    end
  end

endmodule : iic_regs

// ==== bench/iic_regs_asserts.sv ====
`timescale 1ns/100ps
module iic_regs_asserts #(
  parameter int TXN = 8
) (
  input wire logic               mclk,                 // Clock
  input wire logic               reset,                // Sync reset
  input wire logic [7:0]         reg_addr,             // Offset
  input wire logic               reg_wr,               // Write
  input wire logic               reg_rd,               // Read
  input wire iic_pkg::iic_word_t reg_rdata_r,          // Read data
  input wire logic               reg_ack_r,            // Ack
  input wire logic [TXN-1:0]     tx_ctx_irq,           // Tx irqs
  input wire logic [31:0]        top_irq_mask,         // Top mask
  input wire logic               tx_iso_summary_event, // Tx summary
  input wire logic               rx_iso_summary_event, // Rx summary
  input wire logic [31:0]        top_iso_events_r,     // Top events
  input wire logic               irq_out_r             // Irq
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_ACK: assert property ((reg_wr || reg_rd) |=> reg_ack_r)
    else $error("access not acked");
  AST_NOACK: assert property (!(reg_wr || reg_rd) |=> !reg_ack_r)
    else $error("ack without access");
  AST_TX_HI: assert property (reg_rd && reg_addr[7:3] == 5'h12
    |=> reg_rdata_r[31:8] == 24'h0) else $error("tx upper bits set");
  AST_RX_HI: assert property (reg_rd && reg_addr[7:3] == 5'h14
    |=> reg_rdata_r[31:4] == 28'h0) else $error("rx upper bits set");
  // Edge then an immediate read must show the bit
  AST_TX_EDGE: assert property ($rose(tx_ctx_irq[0]) ##1
    (reg_rd && reg_addr == 8'h90) |=> reg_rdata_r[0])
    else $error("tx edge lost");
  AST_TOP: assert property ((top_iso_events_r & 32'hFFFFFF3F) == 0)
    else $error("summary outside bits 6 and 7");
  AST_SUMS: assert property (tx_iso_summary_event == top_iso_events_r[6]
    && rx_iso_summary_event == top_iso_events_r[7])
    else $error("summary port differs from top bit");
  AST_MIE: assert property (!top_irq_mask[31] |=> !irq_out_r)
    else $error("irq while master enable clear");
  AST_GATE: assert property (irq_out_r |-> $past(top_irq_mask[31]) &&
    ($past(top_iso_events_r[7:6]) & $past(top_irq_mask[7:6])) != 2'h0)
    else $error("irq without masked summary");
  C_TX: cover property (tx_iso_summary_event);
  C_RX: cover property (rx_iso_summary_event);
  C_IRQ: cover property (irq_out_r);
endmodule : iic_regs_asserts

// ==== bench/iic_regs_test.sv ====
`timescale 1ns/100ps
module iic_regs_test;
  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic [7:0]         reg_addr = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_wdata = 32'h0;
  logic [7:0]         tx_ctx_irq = 8'h00;
  logic [3:0]         rx_ctx_irq = 4'h0;
  logic [3:0]         rx_mask = 4'h0;
  logic [31:0]        top_irq_mask = 32'h0;
  iic_pkg::iic_word_t reg_rdata_r;
  logic               reg_ack_r, tx_iso_summary_event, rx_iso_summary_event;
  logic               irq_out_r;
  logic [31:0]        top_iso_events_r;
  int                 mismatches = 0;
  int                 samples_checked = 0;

  iic_regs iic_regs_inst (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r),
    .tx_ctx_irq(tx_ctx_irq), .rx_ctx_irq(rx_ctx_irq), .rx_mask(rx_mask),
    .top_irq_mask(top_irq_mask), .tx_iso_summary_event(tx_iso_summary_event),
    .rx_iso_summary_event(rx_iso_summary_event),
    .top_iso_events_r(top_iso_events_r), .irq_out_r(irq_out_r));

  initial forever #50 mclk = ~mclk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tally_and_finish;
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Strobe is one cycle; ack is due at the very next edge
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wr = w;
    reg_rd = !w;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (reg_ack_r !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(a, 1'b0, 32'h0);
    chk(reg_rdata_r, e);
  endtask : rd

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] adr [7] = '{8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'hA4, 8'h00};
    foreach (adr[i]) rd(adr[i], 32'h0);
  endtask : t_reset

  task automatic t_tx_regs;
    acc(8'h90, 1'b1, 32'hFFFFFFFF);
    rd(8'h90, 32'hFF);
    acc(8'h94, 1'b1, 32'h0);
    rd(8'h90, 32'hFF);
    acc(8'h94, 1'b1, 32'h0F);
    rd(8'h90, 32'hF0);
    rd(8'h94, 32'h0);
    acc(8'h98, 1'b1, 32'hFFFFFF30);
    rd(8'h9C, 32'h30);
    acc(8'h9C, 1'b1, 32'h10);
    rd(8'h98, 32'h20);
    rd(8'h94, 32'h20);
    rd(8'h90, 32'hF0);
    chk(tx_iso_summary_event, 32'h1);
    rd(8'h94, 32'h20);
    top_irq_mask = 32'h40;
    repeat (3) @(negedge mclk);
    chk(irq_out_r, 32'h0);
    top_irq_mask = 32'h80000040;
    repeat (3) @(negedge mclk);
    chk(irq_out_r, 32'h1);
    top_irq_mask = 32'h80000080;
    repeat (3) @(negedge mclk);
    chk(irq_out_r, 32'h0);
    acc(8'h9C, 1'b1, 32'hFF);
    repeat (2) @(negedge mclk);
    chk(tx_iso_summary_event, 32'h0);
    acc(8'h94, 1'b1, 32'hFF);
    rd(8'h90, 32'h0);
  endtask : t_tx_regs

  // A level held high must not re-arm after a clear
  task automatic t_tx_edge;
    tx_ctx_irq = 8'h01;
    rd(8'h90, 32'h01);
    acc(8'h94, 1'b1, 32'h01);
    rd(8'h90, 32'h0);
    tx_ctx_irq = 8'h00;
    @(negedge mclk);
    tx_ctx_irq = 8'h81;
    rd(8'h90, 32'h81);
    tx_ctx_irq = 8'h00;
    acc(8'h94, 1'b1, 32'hFF);
  endtask : t_tx_edge

  task automatic t_rx;
    rx_mask = 4'h5;
    rx_ctx_irq = 4'h8;
    rd(8'hA0, 32'h8);
    acc(8'hA0, 1'b1, 32'hFFFFFFFF);
    rd(8'hA0, 32'hF);
    rd(8'hA4, 32'h5);
    chk(rx_iso_summary_event, 32'h1);
    acc(8'hA4, 1'b1, 32'hFFFFFFF5);
    rd(8'hA0, 32'hA);
    rd(8'hA4, 32'h0);
    repeat (2) @(negedge mclk);
    chk(rx_iso_summary_event, 32'h0);
  endtask : t_rx

  initial begin
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    t_reset();
    t_tx_regs();
    t_tx_edge();
    t_rx();
    tally_and_finish();
  end
endmodule : iic_regs_test

bind iic_regs iic_regs_asserts #(.TXN(TXN)) iic_regs_asserts_inst (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r),
  .tx_ctx_irq(tx_ctx_irq), .top_irq_mask(top_irq_mask),
  .tx_iso_summary_event(tx_iso_summary_event),
  .rx_iso_summary_event(rx_iso_summary_event),
  .top_iso_events_r(top_iso_events_r), .irq_out_r(irq_out_r));
